// file: tmr_io_pkg.sv
// Package of register offsets, field positions and reset values for the timer I/O block.
package tmr_io_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IO_CTRL_CH0 = 8'h00;
    localparam logic [7:0] ADDR_IO_CTRL_CH5 = 8'h04;
    localparam logic [7:0] ADDR_MODE_CH0    = 8'h08;
    localparam logic [7:0] ADDR_CH1_CTRL    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS      = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;
    localparam logic [7:0] ADDR_GREG_CH0    = 8'h18;
    localparam logic [7:0] ADDR_GREG_CH5    = 8'h1C;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IO_FIELD_LSB   = 4;
    localparam int BUF_MODE_BIT   = 5;
    localparam int ST_CAP0_BIT    = 0;
    localparam int ST_CAP5_BIT    = 1;
    localparam int ST_OVF_BIT     = 2;
    localparam int ST_UNF_BIT     = 3;
    // ------------------------------------------------------------------
    // Reset values and the undivided prescaler select
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_IO_CTRL  = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_CH1_CTRL = 8'h00;
    localparam logic [3:0] RST_STATUS   = 4'h0;
    localparam logic [3:0] RST_MASK     = 4'h0;
    localparam logic [2:0] PRESCALE_UNDIVIDED = 3'h0;
endpackage : tmr_io_pkg

// file: tmr_io_select.sv
// Timer channel I/O compare and capture selection with APB registers.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Compare mode with nonzero action drives initial pin level from field bit 6.
// - Compare action 01 drives the pin low on compare match.
// - Compare action 10 drives the pin high on compare match.
// - Compare action 11 toggles the pin on compare match.
// - Top bit set with low bits 00 captures on rising source edge.
// - Capture with low bits 01 captures on falling source edge.
// - Capture with bit 5 set captures on both edges.
// - Channel 0 register four with bit 6 clear captures from its own pin.
// - Channel 0 with bits 7 and 6 set captures on channel 1 count.
// - No neighbour capture when channel 1 prescaler select is 000.
// - Buffer mode on channel 0 suppresses its capture and compare actions.
// - Channel 5 register two ignores bit 6 and captures from its pin.
// - Capture sets the capture/compare flag and raises its interrupt.
// - Counter overflow sets the overflow flag and raises its interrupt.
// - Counter underflow sets the underflow flag and raises its interrupt.
module tmr_io_select #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             I_CORE_CLK,
    input  wire logic             I_RESET,
    // APB slave
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    output logic [31:0]           o_prdata,
    // Counter events
    input  wire logic [CNT_W-1:0] i_ch0_count,
    input  wire logic [CNT_W-1:0] i_ch5_count,
    input  wire logic             i_ch0_match,
    input  wire logic             i_ch5_match,
    input  wire logic             i_ch1_count_step,
    input  wire logic             i_overflow,
    input  wire logic             i_underflow,
    // Timer pins
    input  wire logic             i_ch0_pin_four,
    input  wire logic             i_ch5_pin_two,
    output logic                  o_ch0_pin_four,
    output logic                  o_ch0_pin_four_oe,
    output logic                  o_ch5_pin_two,
    output logic                  o_ch5_pin_two_oe,
    // Interrupts
    output logic                  o_capture_compare_irq,
    output logic                  o_overflow_irq,
    output logic                  o_underflow_irq,
    output logic                  o_irq
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]       io_ch0_q, io_ch5_q, mode_ch0_q, ch1_ctrl_q;
    logic [3:0]       status_q, status_d, mask_q;
    logic [CNT_W-1:0] greg0_q, greg5_q;
    logic             pin0_q, pin5_q, pin0_oe_q, pin5_oe_q;
    logic             src0_prev_q, src5_prev_q;
    logic [31:0]      rdata_d;
    logic             irq_d;

    // Decodes the low two bits of the field into edge selection for a pin source.
    function automatic logic edge_hit(input logic [1:0] low, input logic prev,
                                      input logic now);
        logic rise;
        logic fall;
        rise = now & ~prev;
        fall = prev & ~now;
        if (low[1]) edge_hit = rise | fall;
        else if (low[0]) edge_hit = fall;
        else edge_hit = rise;
    endfunction : edge_hit

    // Next pin level on a compare match.
    function automatic logic match_level(input logic [1:0] low, input logic cur);
        unique case (low)
            2'h1: match_level = 1'b0;
            2'h2: match_level = 1'b1;
            2'h3: match_level = ~cur;
            default: match_level = cur;
        endcase
    endfunction : match_level

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire logic [3:0] f0 = io_ch0_q[tmr_io_pkg::IO_FIELD_LSB +: 4];
    wire logic [3:0] f5 = io_ch5_q[tmr_io_pkg::IO_FIELD_LSB +: 4];
    wire logic buf_mode = mode_ch0_q[tmr_io_pkg::BUF_MODE_BIT];
    wire logic ch0_active = ~buf_mode;
    wire logic ch0_neigh_ok = ch1_ctrl_q[2:0] != tmr_io_pkg::PRESCALE_UNDIVIDED;
    wire logic cap0_pin = f0[3] & ~f0[2] & ch0_active
                        & edge_hit(f0[1:0], src0_prev_q, i_ch0_pin_four);
    wire logic cap0_nb  = f0[3] & f0[2] & ch0_active & ch0_neigh_ok
                        & i_ch1_count_step;
    wire logic cap0 = cap0_pin | cap0_nb;
    wire logic cap5 = f5[3] & edge_hit(f5[1:0], src5_prev_q, i_ch5_pin_two);
    wire logic cmp0_en = ~f0[3] & (f0[1:0] != 2'h0) & ch0_active;
    wire logic cmp5_en = ~f5[3] & (f5[1:0] != 2'h0);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic acc     = i_psel & i_penable;
    wire logic wr      = acc & i_pwrite;
    wire logic rd      = acc & ~i_pwrite;
    wire logic mapped  = (i_paddr[1:0] == 2'h0) && (i_paddr <= tmr_io_pkg::ADDR_GREG_CH5);
    wire logic rd_stat = rd & (i_paddr == tmr_io_pkg::ADDR_STATUS);

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (i_paddr)
            tmr_io_pkg::ADDR_IO_CTRL_CH0: rdata_d[7:0] = io_ch0_q;
            tmr_io_pkg::ADDR_IO_CTRL_CH5: rdata_d[7:0] = io_ch5_q;
            tmr_io_pkg::ADDR_MODE_CH0:    rdata_d[7:0] = mode_ch0_q;
            tmr_io_pkg::ADDR_CH1_CTRL:    rdata_d[7:0] = ch1_ctrl_q;
            tmr_io_pkg::ADDR_STATUS:      rdata_d[3:0] = status_q;
            tmr_io_pkg::ADDR_IRQ_MASK:    rdata_d[3:0] = mask_q;
            tmr_io_pkg::ADDR_GREG_CH0:    rdata_d[CNT_W-1:0] = greg0_q;
            tmr_io_pkg::ADDR_GREG_CH5:    rdata_d[CNT_W-1:0] = greg5_q;
            default:                      rdata_d = 32'h0000_0000;
        endcase
    end

    // A read clears only the bits it returned, so an event taken at the setup edge
    // stays pending for the next read; an event in the access cycle wins as well.
    always_comb begin
        status_d = rd_stat ? (status_q & ~o_prdata[3:0]) : status_q;
        if (cap0) status_d[tmr_io_pkg::ST_CAP0_BIT] = 1'b1;
        if (cap5) status_d[tmr_io_pkg::ST_CAP5_BIT] = 1'b1;
        if (i_overflow) status_d[tmr_io_pkg::ST_OVF_BIT] = 1'b1;
        if (i_underflow) status_d[tmr_io_pkg::ST_UNF_BIT] = 1'b1;
    end
    assign irq_d = |(status_d & mask_q);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            io_ch0_q   <= tmr_io_pkg::RST_IO_CTRL;
            io_ch5_q   <= tmr_io_pkg::RST_IO_CTRL;
            mode_ch0_q <= tmr_io_pkg::RST_MODE;
            ch1_ctrl_q <= tmr_io_pkg::RST_CH1_CTRL;
            mask_q     <= tmr_io_pkg::RST_MASK;
            o_prdata   <= 32'h0000_0000;
            o_pslverr  <= 1'b0;
            o_pready   <= 1'b0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~mapped;
            o_prdata  <= rdata_d;
            if (wr & o_pready) begin
                unique case (i_paddr)
                    tmr_io_pkg::ADDR_IO_CTRL_CH0: io_ch0_q   <= i_pwdata[7:0];
                    tmr_io_pkg::ADDR_IO_CTRL_CH5: io_ch5_q   <= i_pwdata[7:0];
                    tmr_io_pkg::ADDR_MODE_CH0:    mode_ch0_q <= i_pwdata[7:0];
                    tmr_io_pkg::ADDR_CH1_CTRL:    ch1_ctrl_q <= i_pwdata[7:0];
                    tmr_io_pkg::ADDR_IRQ_MASK:    mask_q     <= i_pwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Status and interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            status_q              <= tmr_io_pkg::RST_STATUS;
            o_irq                 <= 1'b0;
            o_capture_compare_irq <= 1'b0;
            o_overflow_irq        <= 1'b0;
            o_underflow_irq       <= 1'b0;
        end else begin
            status_q              <= (rd_stat & o_pready) ? status_d
                                   : (status_d | status_q);
            o_irq                 <= irq_d;
            o_capture_compare_irq <= status_d[0] | status_d[1];
            o_overflow_irq        <= status_d[tmr_io_pkg::ST_OVF_BIT];
            o_underflow_irq       <= status_d[tmr_io_pkg::ST_UNF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Capture registers and pin drive
    // ------------------------------------------------------------------
    // The previous-level samples run through reset, so a pin already high when
    // reset ends is not mistaken for a rising edge.
    always_ff @(posedge I_CORE_CLK) begin
        src0_prev_q <= i_ch0_pin_four;
        src5_prev_q <= i_ch5_pin_two;
        if (I_RESET) begin
            greg0_q <= '0;
            greg5_q <= '0;
        end else begin
            if (cap0) greg0_q <= i_ch0_count;
            if (cap5) greg5_q <= i_ch5_count;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            pin0_q    <= 1'b0;
            pin5_q    <= 1'b0;
            pin0_oe_q <= 1'b0;
            pin5_oe_q <= 1'b0;
        end else begin
            pin0_oe_q <= cmp0_en;
            pin5_oe_q <= cmp5_en;
            if (!cmp0_en) pin0_q <= f0[2];
            else if (!pin0_oe_q) pin0_q <= f0[2];
            else if (i_ch0_match) pin0_q <= match_level(f0[1:0], pin0_q);
            if (!cmp5_en) pin5_q <= f5[2];
            else if (!pin5_oe_q) pin5_q <= f5[2];
            else if (i_ch5_match) pin5_q <= match_level(f5[1:0], pin5_q);
        end
    end

    assign o_ch0_pin_four    = pin0_q;
    assign o_ch0_pin_four_oe = pin0_oe_q;
    assign o_ch5_pin_two     = pin5_q;
    assign o_ch5_pin_two_oe  = pin5_oe_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    toggle_match_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin5_oe_q && cmp5_en && f5[1:0] == 2'h3 && i_ch5_match)
        |=> (pin5_q != $past(pin5_q))) else $error("Toggle on match missing");
    low_match_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin5_oe_q && cmp5_en && f5[1:0] == 2'h1 && i_ch5_match) |=> !pin5_q)
        else $error("Pin not low after match");
    high_match_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin0_oe_q && cmp0_en && f0[1:0] == 2'h2 && i_ch0_match) |=> pin0_q)
        else $error("Pin not high after match");
    init_level_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (cmp5_en && !pin5_oe_q) |=> (pin5_q == $past(f5[2])))
        else $error("Initial level wrong");
    disabled_pin_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (!f5[3] && f5[1:0] == 2'h0) |=> !pin5_oe_q)
        else $error("Pin driven while disabled");
    buffer_block_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        buf_mode |-> !cap0 && !cmp0_en) else $error("Buffer mode leaked action");
    neigh_prescale_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (ch1_ctrl_q[2:0] == 3'h0) |-> !cap0_nb) else $error("Neighbour capture at div1");
    capture_copy_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        cap5 |=> (greg5_q == $past(i_ch5_count)) && status_q[1])
        else $error("Capture not stored");
    ovf_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        i_overflow |=> status_q[2] && o_overflow_irq) else $error("Overflow flag missing");
    unf_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        i_underflow |=> status_q[3] && o_underflow_irq) else $error("Underflow flag missing");
    rise_cap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f5[3] && f5[1:0] == 2'h0 && $rose(i_ch5_pin_two)) |-> cap5)
        else $error("Rising capture missed");

    // ------------------------------------------------------------------
    // Checks on channel 0, channel 5 compare, the capture sources, status and the bus
    // ------------------------------------------------------------------
    ch0_toggle_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin0_oe_q && cmp0_en && f0[1:0] == 2'h3 && i_ch0_match)
        |=> (pin0_q != $past(pin0_q)))
        else $error("Channel 0 toggle on match missing");
    ch0_low_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin0_oe_q && cmp0_en && f0[1:0] == 2'h1 && i_ch0_match)
        |=> !pin0_q)
        else $error("Channel 0 pin not low after match");
    ch5_high_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin5_oe_q && cmp5_en && f5[1:0] == 2'h2 && i_ch5_match)
        |=> pin5_q)
        else $error("Channel 5 pin not high after match");
    pin_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (pin5_oe_q && cmp5_en && !i_ch5_match)
        |=> $stable(pin5_q))
        else $error("Pin moved without a match");
    ch0_init_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (cmp0_en && !pin0_oe_q)
        |=> (pin0_q == $past(f0[2])))
        else $error("Channel 0 initial level wrong");
    ch0_disabled_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (!f0[3] && f0[1:0] == 2'h0)
        |=> !pin0_oe_q)
        else $error("Channel 0 pin driven while disabled");
    buffer_pin_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        buf_mode
        |=> !pin0_oe_q)
        else $error("Channel 0 pin driven in buffer mode");
    fall_cap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f5[3] && f5[1:0] == 2'h1 && $fell(i_ch5_pin_two))
        |-> cap5)
        else $error("Falling capture missed");
    both_cap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f5[3] && f5[1] && $changed(i_ch5_pin_two))
        |-> cap5)
        else $error("Both-edge capture missed");
    ch5_bit6_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f5[3] && f5[2] && f5[1:0] == 2'h0 && $rose(i_ch5_pin_two))
        |-> cap5)
        else $error("Channel 5 capture lost to bit 6");
    own_pin_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f0[3] && !f0[2] && !buf_mode && f0[1:0] == 2'h0 && $rose(i_ch0_pin_four))
        |-> cap0)
        else $error("Channel 0 pin capture missed");
    neigh_step_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f0[3] && f0[2] && !buf_mode && i_ch1_count_step
         && ch1_ctrl_q[2:0] != tmr_io_pkg::PRESCALE_UNDIVIDED) |-> cap0)
        else $error("Neighbour step capture missed");
    neigh_only_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (f0[3] && f0[2] && !i_ch1_count_step)
        |-> !cap0)
        else $error("Neighbour mode captured without a step");
    ch0_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        cap0
        |=> (status_q[tmr_io_pkg::ST_CAP0_BIT] && o_capture_compare_irq))
        else $error("Channel 0 capture flag missing");
    ch0_copy_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        cap0
        |=> (greg0_q == $past(i_ch0_count)))
        else $error("Channel 0 capture not stored");
    status_sticky_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        !rd_stat
        |=> ((status_q & $past(status_q)) == $past(status_q)))
        else $error("Status bit lost without a read");
    irq_level_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (((status_q & mask_q) != 4'h0) && !rd_stat)
        |=> o_irq)
        else $error("Interrupt output low with an unmasked flag");
    ready_answer_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (i_psel && !i_penable)
        |=> o_pready)
        else $error("Bus access not answered");
    ready_pulse_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (o_pready && i_penable)
        |=> !o_pready)
        else $error("Ready held past the access");
endmodule : tmr_io_select
`default_nettype wire

// file: tmr_io_far_model.sv
// Far-side model of the timer pins, the channel counter and the counter events.
`timescale 1ns/100ps
`default_nettype none
module tmr_io_far_model (
    // Clock
    input  wire logic        i_clk,
    // Pins and counter
    output logic             o_ch0_pin,
    output logic             o_ch5_pin,
    output logic [15:0]      o_count,
    // Events: match ch0, match ch5, ch1 step, overflow, underflow
    output logic [4:0]       o_ev
);
    initial begin
        o_ch0_pin = 1'b0;
        o_ch5_pin = 1'b0;
        o_count   = 16'h0000;
        o_ev      = 5'h00;
    end

    // Pin levels and counter value change together just after an edge.
    task automatic drive(input logic p0, input logic p5, input logic [15:0] c);
        @(posedge i_clk);
        o_ch0_pin <= p0;
        o_ch5_pin <= p5;
        o_count   <= c;
    endtask : drive

    // Each event is a one-cycle pulse.
    task automatic pulse(input int k);
        @(posedge i_clk);
        o_ev[k] <= 1'b1;
        @(posedge i_clk);
        o_ev[k] <= 1'b0;
    endtask : pulse
endmodule : tmr_io_far_model
`default_nettype wire

// file: tmr_io_select_tb.sv
// Self-checking testbench of the timer I/O compare and capture block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tmr_io_select_tb;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        ch0_pin;
    logic        ch5_pin;
    logic [15:0] count;
    logic [4:0]  ev;
    wire logic [1:0] pin0;
    wire logic [1:0] pin5;
    wire logic [3:0] irqs;
    logic [7:0]  ra;
    logic        sel_ch;
    logic [31:0] rd;
    logic        err;
    int          n_fail = 0;
    int          samples_checked = 0;
    // Compare rows {oe, initial level, level after match}; capture rows {field, rise, fall}.
    logic [2:0]  cmp_rows [8] = '{3'h0, 3'h4, 3'h5, 3'h5, 3'h0, 3'h6, 3'h7, 3'h6};
    logic [5:0]  cap_rows [6] = '{6'h22, 6'h25, 6'h2B, 6'h2F, 6'h32, 6'h35};
    wire logic [1:0] pin_st = sel_ch ? pin5 : pin0;

    tmr_io_select i_tmr_io_select (
        .I_CORE_CLK(clk), .I_RESET(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .i_ch0_count(count), .i_ch5_count(count),
        .i_ch0_match(ev[0]), .i_ch5_match(ev[1]), .i_ch1_count_step(ev[2]),
        .i_overflow(ev[3]), .i_underflow(ev[4]), .i_ch0_pin_four(ch0_pin),
        .i_ch5_pin_two(ch5_pin), .o_ch0_pin_four(pin0[0]), .o_ch0_pin_four_oe(pin0[1]),
        .o_ch5_pin_two(pin5[0]), .o_ch5_pin_two_oe(pin5[1]), .o_capture_compare_irq(irqs[3]),
        .o_overflow_irq(irqs[2]), .o_underflow_irq(irqs[1]), .o_irq(irqs[0]));

    tmr_io_far_model i_tmr_io_far_model (
        .i_clk(clk), .o_ch0_pin(ch0_pin), .o_ch5_pin(ch5_pin), .o_count(count), .o_ev(ev));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
    endtask : apb

    // One capture attempt on the selected channel, from a pin edge or a channel 1 step.
    task automatic cap_try(input logic step, input logic lvl, input logic expc,
                           input logic [15:0] cv);
        i_tmr_io_far_model.drive(sel_ch ? 1'b0 : lvl, sel_ch ? lvl : 1'b0, cv);
        if (step) begin
            i_tmr_io_far_model.pulse(2);
        end
        cyc(3);
        `CHK(irqs[3], expc)
        apb(1'b0, tmr_io_pkg::ADDR_STATUS, 32'h0);
        `CHK(rd, {31'h0, expc} << sel_ch)
        if (expc) begin
            apb(1'b0, sel_ch ? tmr_io_pkg::ADDR_GREG_CH5 : tmr_io_pkg::ADDR_GREG_CH0, 32'h0);
            `CHK(rd, {16'h0, cv})
        end
    endtask : cap_try

    initial begin
        #(40 * 100000);
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sel_ch = 1'b0;
        cyc(10);
        rst <= 1'b0;
        for (int a = 0; a < 32; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            `CHK({err, rd}, 33'h0)
        end
        `CHK(pin0[1], 1'b0)
        `CHK(irqs, 4'h0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        $display("Test reset and map done");
        for (int ch = 0; ch < 2; ch++) begin
            sel_ch = ch[0];
            for (int f = 0; f < 8; f++) begin
                ra = ch[0] ? tmr_io_pkg::ADDR_IO_CTRL_CH5 : tmr_io_pkg::ADDR_IO_CTRL_CH0;
                apb(1'b1, ra, 32'h0);
                apb(1'b1, ra, 32'(f) << 4);
                cyc(3);
                `CHK({pin_st[1], pin_st[0] & cmp_rows[f][2]}, cmp_rows[f][2:1])
                i_tmr_io_far_model.pulse(ch);
                cyc(3);
                `CHK({pin_st[1], pin_st[0] & cmp_rows[f][2]}, {cmp_rows[f][2], cmp_rows[f][0]})
            end
        end
        $display("Test compare modes done");
        apb(1'b0, tmr_io_pkg::ADDR_STATUS, 32'h0);
        for (int ch = 0; ch < 2; ch++) begin
            sel_ch = ch[0];
            for (int r = 0; r < (ch ? 6 : 4); r++) begin
                ra = ch[0] ? tmr_io_pkg::ADDR_IO_CTRL_CH5 : tmr_io_pkg::ADDR_IO_CTRL_CH0;
                apb(1'b1, ra, {24'h0, cap_rows[r][5:2], 4'h0});
                cap_try(1'b0, 1'b1, cap_rows[r][1], 16'h1230 + 16'(r));
                cap_try(1'b0, 1'b0, cap_rows[r][0], 16'hABC0 + 16'(r));
            end
        end
        $display("Test capture edges done");
        sel_ch = 1'b0;
        apb(1'b1, tmr_io_pkg::ADDR_IO_CTRL_CH0, 32'hC0);
        cap_try(1'b0, 1'b1, 1'b0, 16'h0011);
        cap_try(1'b0, 1'b0, 1'b0, 16'h0012);
        apb(1'b1, tmr_io_pkg::ADDR_CH1_CTRL, 32'h0);
        cap_try(1'b1, 1'b0, 1'b0, 16'h0013);
        apb(1'b1, tmr_io_pkg::ADDR_CH1_CTRL, 32'h1);
        cap_try(1'b1, 1'b0, 1'b1, 16'h0C0C);
        apb(1'b1, tmr_io_pkg::ADDR_MODE_CH0, 32'h20);
        apb(1'b1, tmr_io_pkg::ADDR_IO_CTRL_CH0, 32'h80);
        cap_try(1'b0, 1'b1, 1'b0, 16'h0021);
        cap_try(1'b0, 1'b0, 1'b0, 16'h0022);
        $display("Test neighbour and buffer done");
        i_tmr_io_far_model.pulse(3);
        cyc(3);
        `CHK(irqs[2:0], 3'h4)
        apb(1'b1, tmr_io_pkg::ADDR_IRQ_MASK, 32'h8);
        i_tmr_io_far_model.pulse(4);
        cyc(3);
        `CHK(irqs[2:0], 3'h7)
        apb(1'b0, tmr_io_pkg::ADDR_STATUS, 32'h0);
        `CHK(rd, 32'hC)
        cyc(3);
        `CHK(irqs[2:0], 3'h0)
        $display("Test overflow and underflow done");
        report_and_stop();
    end
endmodule : tmr_io_select_tb
`default_nettype wire
